// ===== rtl/xcp_config_host.sv
// apb-controlled host that programs the crosspoint configuration port
`timescale 1ns/100ps
module xcp_config_host (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins
    output xcp_pkg::xcp_pins_s pins,
    input wire logic [6:0] routeIn
);
    import xcp_pkg::*;

    // ======================================================================
    // apb register access
    logic transpFf;
    logic [4:0] selFf;
    logic [6:0] routeFf;
    logic refusedFf;
    logic [6:0] readValFf;
    logic [31:0] prdataFf;
    logic slvErrFf;
    xcp_state_e stateFf;
    logic setup;
    logic wrAccess;
    logic cmdWrite;
    logic refuse;
    logic start;
    logic [1:0] cmdOp;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == REG_CTRL) || (a == REG_SEL) || (a == REG_ROUTE) ||
            (a == REG_CMD) || (a == REG_STATUS) || (a == REG_READ);
    endfunction

    assign setup = psel && !penable;
    assign wrAccess = psel && penable && pwrite && ce;
    assign cmdWrite = wrAccess && (paddr == REG_CMD);
    assign cmdOp = pwdata[1:0];
    // illegal codes are refused before any pin moves
    always_comb begin
        refuse = 1'b0;
        if (selFf > SEL_BCAST) begin
            refuse = 1'b1;
        end else if (cmdOp == OP_READ && selFf == SEL_BCAST) begin
            refuse = 1'b1;
        end else if (cmdOp == OP_WRITE && routeFf[5:0] > INPUT_MAX) begin
            refuse = 1'b1;
        end
    end
    assign start = cmdWrite && (stateFf == XCP_IDLE) && !refuse &&
        ((cmdOp == OP_UPDATE) || (cmdOp == OP_RESET) || (selFf <= SEL_BCAST));
    assign pready = ce;
    assign prdata = prdataFf;
    assign pslverr = slvErrFf;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdataFf <= 32'h0000_0000;
            slvErrFf <= 1'b0;
        end else if (ce && setup) begin
            slvErrFf <= !mapped(paddr);
            if (paddr == REG_CTRL) begin
                prdataFf <= {31'h0, transpFf};
            end else if (paddr == REG_SEL) begin
                prdataFf <= {27'h0, selFf};
            end else if (paddr == REG_ROUTE) begin
                prdataFf <= {25'h0, routeFf};
            end else if (paddr == REG_STATUS) begin
                prdataFf <= {30'h0, refusedFf, stateFf != XCP_IDLE};
            end else if (paddr == REG_READ) begin
                prdataFf <= {25'h0, readValFf};
            end else begin
                prdataFf <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            transpFf <= 1'b0;
            selFf <= SEL_RST;
            routeFf <= ROUTE_RST;
        end else if (wrAccess) begin
            if (paddr == REG_CTRL) begin
                transpFf <= pwdata[CTRL_TRANSP_BIT];
            end else if (paddr == REG_SEL) begin
                selFf <= pwdata[4:0];
            end else if (paddr == REG_ROUTE) begin
                routeFf <= pwdata[6:0];
            end
        end
    end

    // sticky refusal flag, a new refusal wins over the clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refusedFf <= 1'b0;
        end else if (ce) begin
            if (cmdWrite && refuse) begin
                refusedFf <= 1'b1;
            end else if (wrAccess && paddr == REG_STATUS && pwdata[STAT_REFUSED_BIT]) begin
                refusedFf <= 1'b0;
            end
        end
    end

    // ======================================================================
    // readback synchroniser, a change counts once stages two and three agree
    logic [6:0] sync1Ff;
    logic [6:0] sync2Ff;
    logic [6:0] sync3Ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1Ff <= ROUTE_RST;
            sync2Ff <= ROUTE_RST;
            sync3Ff <= ROUTE_RST;
        end else if (ce) begin
            sync1Ff <= routeIn;
            sync2Ff <= sync1Ff;
            sync3Ff <= sync2Ff;
        end
    end

    // ======================================================================
    // pin sequencer
    logic [1:0] opFf;
    logic [4:0] opSelFf;
    logic [6:0] opRouteFf;
    logic opTranspFf;
    logic [2:0] cntFf;
    logic cntDone;
    logic sampleOk;
    assign cntDone = (cntFf == 3'h0);
    assign sampleOk = (sync2Ff == sync3Ff);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateFf <= XCP_IDLE;
            cntFf <= 3'h0;
            opFf <= OP_WRITE;
            opSelFf <= SEL_RST;
            opRouteFf <= ROUTE_RST;
            opTranspFf <= 1'b0;
        end else if (ce) begin
            if (!cntDone) begin
                cntFf <= cntFf - 3'h1;
            end
            case (stateFf)
                XCP_IDLE: begin
                    if (start) begin
                        opFf <= cmdOp;
                        opSelFf <= selFf;
                        opRouteFf <= routeFf;
                        opTranspFf <= transpFf;
                        if (cmdOp == OP_WRITE) begin
                            stateFf <= XCP_SETUP;
                            cntFf <= 3'(C_DSW - 1);
                        end else begin
                            stateFf <= XCP_STROBE;
                            if (cmdOp == OP_UPDATE) begin
                                cntFf <= 3'(C_UW - 1);
                            end else if (cmdOp == OP_RESET) begin
                                cntFf <= 3'(C_TW - 1);
                            end else begin
                                cntFf <= 3'(C_RD - 1);
                            end
                        end
                    end
                end
                XCP_SETUP: begin
                    if (cntDone) begin
                        stateFf <= XCP_STROBE;
                        cntFf <= 3'(C_WP - 1);
                    end
                end
                XCP_STROBE: begin
                    if (cntDone) begin
                        if (opFf == OP_WRITE) begin
                            stateFf <= XCP_GAP;
                            cntFf <= 3'(C_WHU - 1);
                        end else if (opFf == OP_READ) begin
                            if (sampleOk) begin
                                stateFf <= XCP_RDREL;
                                cntFf <= 3'(C_REL - 1);
                            end
                        end else if (opFf == OP_UPDATE) begin
                            stateFf <= XCP_SETTLE;
                            cntFf <= 3'(C_UOE - 1);
                        end else begin
                            stateFf <= XCP_SETTLE;
                            cntFf <= 3'(C_TOD - 1);
                        end
                    end
                end
                XCP_GAP: begin
                    if (cntDone) begin
                        if (opTranspFf) begin
                            stateFf <= XCP_SETTLE;
                            cntFf <= 3'(C_UOE - 1);
                        end else begin
                            stateFf <= XCP_IDLE;
                        end
                    end
                end
                XCP_SETTLE, XCP_RDREL: begin
                    if (cntDone) begin
                        stateFf <= XCP_IDLE;
                    end
                end
                default: begin
                    stateFf <= XCP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readValFf <= ROUTE_RST;
        end else if (ce && stateFf == XCP_STROBE && opFf == OP_READ && cntDone && sampleOk) begin
            readValFf <= sync3Ff;
        end
    end

    // registered pins, decoded from the sequencer state
    logic inWrite;
    logic inXfer;
    assign inWrite = (opFf == OP_WRITE) &&
        (stateFf == XCP_SETUP || stateFf == XCP_STROBE || stateFf == XCP_GAP);
    assign inXfer = inWrite || stateFf == XCP_STROBE || stateFf == XCP_RDREL;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins <= PINS_RST;
        end else if (ce) begin
            pins.csN <= !(inXfer && opFf != OP_RESET);
            pins.weN <= !(stateFf == XCP_STROBE && opFf == OP_WRITE);
            pins.updateN <= !((stateFf == XCP_STROBE && opFf == OP_UPDATE) ||
                (inWrite && opTranspFf));
            pins.readbackStrobeN <= !(stateFf == XCP_STROBE && opFf == OP_READ);
            pins.resetN <= !(stateFf == XCP_STROBE && opFf == OP_RESET);
            pins.outSel <= opSelFf;
            pins.routeOut <= opRouteFf;
            pins.routeOeN <= !inWrite;
        end
    end

    // ======================================================================
    // checks on the driven pins
    weWidth_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(pins.weN) |-> !pins.weN [*2])
        else $error("write strobe shorter than 15 ns");
    updWidth_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(pins.updateN) |-> !pins.updateN [*2])
        else $error("transfer strobe shorter than 15 ns");
    rstWidth_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(pins.resetN) |-> !pins.resetN [*2])
        else $error("global reset shorter than 15 ns");
    wrToUpd_a: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(pins.weN) && pins.updateN) |-> pins.updateN [*2])
        else $error("transfer strobe too soon after write strobe");
    noBcastRead_a: assert property (@(posedge clk) disable iff (sys_rst)
        !pins.readbackStrobeN |-> pins.outSel != SEL_BCAST)
        else $error("readback with broadcast select");
    legalCode_a: assert property (@(posedge clk) disable iff (sys_rst)
        !pins.weN |-> (pins.outSel <= SEL_BCAST && pins.routeOut[5:0] <= INPUT_MAX))
        else $error("reserved code written");
    selHold_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(pins.readbackStrobeN) |-> $stable(pins.outSel) && !pins.csN)
        else $error("select changed right after readback");
    busFree_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(pins.readbackStrobeN) |-> pins.routeOeN [*4])
        else $error("bus driven before readback release time");
    dataSetup_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(pins.weN) |-> !pins.csN && !$past(pins.routeOeN, 2))
        else $error("route word not set up before write strobe");
    readDone_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        $fell(pins.readbackStrobeN) |-> ##[5:40] pins.readbackStrobeN)
        else $error("readback strobe never released");
endmodule

// ===== rtl/xcp_pkg.sv
// constants and types of the crosspoint configuration port controller
// ==========================================================================
package xcp_pkg;
    // ======================================================================
    // register map (byte offsets)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SEL = 8'h04;
    localparam logic [7:0] REG_ROUTE = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_READ = 8'h14;
    localparam int CTRL_TRANSP_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int ROUTE_EN_BIT = 6;
    localparam logic [4:0] SEL_BCAST = 5'h11;
    localparam logic [5:0] INPUT_MAX = 6'h20;
    localparam logic [6:0] ROUTE_RST = 7'h00;
    localparam logic [4:0] SEL_RST = 5'h00;
    // ======================================================================
    // commands
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_UPDATE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_RESET = 2'h3;
    // ======================================================================
    // timing, ns and cycles at 125 MHz
    localparam int CLK_PS = 8000;
    localparam int T_DSW_NS = 15;
    localparam int T_WP_NS = 15;
    localparam int T_WHU_NS = 10;
    localparam int T_UW_NS = 15;
    localparam int T_TW_NS = 15;
    localparam int T_UOE_NS = 40;
    localparam int T_TOD_NS = 30;
    localparam int T_RDE_NS = 15;
    localparam int T_RDD_NS = 30;
    localparam int T_RHA_NS = 5;
    localparam int SYNC_STAGES = 3;
    localparam int C_DSW = (T_DSW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_WP = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_WHU = (T_WHU_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_UW = (T_UW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_TW = (T_TW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_UOE = (T_UOE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_TOD = (T_TOD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_RD = (T_RDE_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_STAGES;
    localparam int C_RHA = (T_RHA_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_RDD = (T_RDD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int C_REL = (C_RDD > C_RHA) ? C_RDD : C_RHA;
    // ======================================================================
    // types
    typedef enum logic [5:0] {
        XCP_IDLE = 6'b000001,
        XCP_SETUP = 6'b000010,
        XCP_STROBE = 6'b000100,
        XCP_GAP = 6'b001000,
        XCP_SETTLE = 6'b010000,
        XCP_RDREL = 6'b100000
    } xcp_state_e;
    typedef struct packed {
        logic csN;
        logic weN;
        logic updateN;
        logic readbackStrobeN;
        logic resetN;
        logic [4:0] outSel;
        logic [6:0] routeOut;
        logic routeOeN;
    } xcp_pins_s;
    localparam xcp_pins_s PINS_RST = '{csN: 1'b1, weN: 1'b1, updateN: 1'b1,
        readbackStrobeN: 1'b1, resetN: 1'b1, outSel: SEL_RST, routeOut: ROUTE_RST,
        routeOeN: 1'b1};
endpackage

// ===== verif/xcp_dev_model.sv
// behavioural model of the crosspoint configuration port seen from its pins
`timescale 1ns/100ps
module xcp_dev_model (
    // host pins
    input wire xcp_pkg::xcp_pins_s pins,
    // bus level at the host
    output logic [6:0] routeIn,
    // host misbehaviour count
    output int violations
);
    import xcp_pkg::*;
    logic [6:0] rank1 [17];
    logic [6:0] rank2 [17];
    logic [6:0] lvl = 7'h00;
    realtime weFall = -100.0;
    realtime weRise = -100.0;
    realtime upFall = -100.0;
    realtime rbRise = -100.0;
    realtime rstFall = -100.0;
    // readback drivers turn on and off with a lag
    wire #(15, 20) rdOn = !pins.csN && !pins.readbackStrobeN;
    assign routeIn = lvl;
    initial violations = 0;
    task automatic bad(input string msg);
        violations++;
        $display("unexpected host pin activity: %s", msg);
    endtask
    // ======================================================================
    // bus level: a released bus shows a changing pattern, not the last value
    always @(pins or rdOn) begin
        if (!pins.routeOeN && rdOn) bad("bus contention");
        if (!pins.routeOeN) lvl = pins.routeOut;
        else if (rdOn) lvl = rank2[pins.outSel];
        else lvl = ~lvl;
    end
    // ======================================================================
    // level-sensitive latches, reset is not gated by chip select
    always @(pins or lvl) begin
        if (!pins.resetN) begin
            for (int i = 0; i < 17; i++) rank2[i][6] = 1'b0;
        end else if (!pins.csN) begin
            if (!pins.weN && pins.outSel == SEL_BCAST) begin
                for (int i = 0; i < 17; i++) rank1[i] = lvl;
            end else if (!pins.weN && pins.outSel < 5'h11) begin
                rank1[pins.outSel] = lvl;
            end
            if (!pins.updateN) rank2 = rank1;
        end
    end
    // ======================================================================
    // host timing and code checks
    always @(negedge pins.weN) begin
        weFall = $realtime;
        if (pins.outSel > SEL_BCAST || lvl[5:0] > INPUT_MAX) bad("reserved code");
    end
    always @(posedge pins.weN) begin
        weRise = $realtime;
        if (weRise - weFall < 15.0) bad("short write strobe");
    end
    always @(negedge pins.updateN) begin
        upFall = $realtime;
        if (upFall - weRise < 10.0) bad("transfer too soon after write");
    end
    always @(posedge pins.updateN) if ($realtime - upFall < 15.0) bad("short transfer");
    always @(negedge pins.readbackStrobeN) if (pins.outSel == SEL_BCAST) bad("bcast read");
    always @(posedge pins.readbackStrobeN) if (pins.csN === 1'b0) rbRise = $realtime;
    always @(pins.outSel) if ($realtime - rbRise < 5.0) bad("select moved early");
    always @(negedge pins.resetN) rstFall = $realtime;
    always @(posedge pins.resetN) if ($realtime - rstFall < 15.0) bad("short reset");
endmodule

// ===== verif/test_crosspoint_config_port.sv
// self-checking testbench of the crosspoint configuration port host
`timescale 1ns/100ps
module test_crosspoint_config_port;
    import xcp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    xcp_pins_s pins;
    logic [6:0] routeIn;
    int violations;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic err;
    always #4 clk = ~clk;
    xcp_config_host uut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .routeIn(routeIn));
    xcp_dev_model dev (.pins(pins), .routeIn(routeIn), .violations(violations));
    // ======================================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic command(input logic [4:0] sel, input logic [6:0] route, input logic [1:0] op);
        int n = 0;
        apb(1'b1, REG_SEL, {27'h0, sel});
        apb(1'b1, REG_ROUTE, {25'h0, route});
        apb(1'b1, REG_CMD, {30'h0, op});
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 100);
        check("busy clears", {31'h0, rd[STAT_BUSY_BIT]}, 32'h0);
    endtask
    // ======================================================================
    // scenarios
    task automatic test_reset_values;
        check("pins at reset", {14'h0, pins}, {14'h0, PINS_RST});
        apb(1'b0, REG_STATUS, 32'h0);
        check("status at reset", rd, 32'h0);
    endtask
    task automatic test_broadcast_route;
        command(SEL_BCAST, 7'h47, OP_WRITE);
        command(5'h10, 7'h60, OP_WRITE);
        command(5'h00, 7'h00, OP_UPDATE);
        for (int i = 0; i < 17; i++) begin
            check("live route", dev.rank2[i], (i == 16) ? 7'h60 : 7'h47);
        end
        command(5'h10, 7'h00, OP_READ);
        apb(1'b0, REG_READ, 32'h0);
        check("readback output 16", rd, 32'h60);
    endtask
    task automatic test_disable;
        command(5'h03, 7'h1F, OP_WRITE);
        check("held in rank one", dev.rank2[3], 7'h47);
        command(5'h00, 7'h00, OP_UPDATE);
        check("output 3 disabled", dev.rank2[3], 7'h1F);
        command(5'h03, 7'h00, OP_READ);
        apb(1'b0, REG_READ, 32'h0);
        check("readback output 3", rd, 32'h1F);
    endtask
    task automatic test_transparent;
        apb(1'b1, REG_CTRL, 32'h1);
        command(5'h05, 7'h41, OP_WRITE);
        check("transparent write live", dev.rank2[5], 7'h41);
        apb(1'b1, REG_CTRL, 32'h0);
    endtask
    task automatic test_refusals;
        logic [4:0] sels [3] = '{SEL_BCAST, 5'h02, 5'h12};
        logic [6:0] routes [3] = '{7'h00, 7'h61, 7'h41};
        logic [1:0] ops [3] = '{OP_READ, OP_WRITE, OP_WRITE};
        for (int k = 0; k < 3; k++) begin
            command(sels[k], routes[k], ops[k]);
            apb(1'b0, REG_STATUS, 32'h0);
            check("refused flag", {31'h0, rd[STAT_REFUSED_BIT]}, 32'h1);
            apb(1'b1, REG_STATUS, 32'h2);
        end
        check("rank one untouched", dev.rank1[2], 7'h47);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped read", rd, 32'h0);
    endtask
    task automatic test_clock_enable;
        xcp_pins_s held;
        int n = 0;
        held = pins;
        apb(1'b1, REG_CMD, {30'h0, OP_UPDATE});
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        check("pins frozen by enable", {14'h0, pins}, {14'h0, held});
        check("ready dropped by enable", {31'h0, pready}, 32'h0);
        ce <= 1'b1;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 100);
        check("busy clears after enable", {31'h0, rd[STAT_BUSY_BIT]}, 32'h0);
    endtask
    task automatic test_device_reset;
        command(5'h00, 7'h00, OP_RESET);
        for (int i = 0; i < 17; i++) begin
            check("enable cleared", {31'h0, dev.rank2[i][6]}, 32'h0);
        end
        check("input bits kept", {26'h0, dev.rank2[16][5:0]}, 32'h20);
        command(5'h00, 7'h00, OP_UPDATE);
        check("rank one restores", dev.rank2[16], 7'h60);
    endtask
    // ======================================================================
    // verdict and sequence
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        test_reset_values;
        test_broadcast_route;
        test_disable;
        test_transparent;
        test_refusals;
        test_clock_enable;
        test_device_reset;
        check("host pin violations", violations, 32'h0);
        print_verdict;
    end
    initial begin
        #400000;
        num_errors++;
        $display("unexpected stall: watchdog expired");
        print_verdict;
    end
endmodule
